// ### hdl/spp_port.sv
// Peripheral-mode serial port, sampling an external serial clock on mclk.
// Assumes the serial clock is slow enough to be oversampled (at least
// 25 ns period) and that the host frames every 16-bit word by chip select.

// Function
// (R01) Peripheral mode when controller-select bit clear
// (R02) Phase bit selects clock phase 0/1
// (R03) Polarity bit selects active clock edge
// (R04) Serial clock period bounded by prescale
// (R05) Output bit launched after rising/falling edge
// (R06) Host waits two clocks after select
// (R07) Host toggles select every 16 bits
// (R08) MSB first; 16th edge completes word
module spp_port #(
    parameter int unsigned WORD_W = spp_pkg::WORD_BITS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Configuration words
    input wire logic [31:0] global_control_reg,
    input wire logic [31:0] format_reg,
    // Serial link pins
    input wire logic serial_clk_in,
    input wire logic chip_sel_n,
    input wire logic controller_out_line,
    output logic peripheral_out_line,
    output logic peripheral_out_oe,
    // Word interface
    input wire logic [WORD_W-1:0] tx_word,
    output logic tx_taken,
    output logic [WORD_W-1:0] rx_word,
    output logic rx_valid,
    // Status
    output spp_pkg::spp_status_type status
);

    typedef enum logic [2:0] {
        SPP_IDLE = 3'b001,
        SPP_SHIFT = 3'b010,
        SPP_DONE = 3'b100
    } spp_state_type;

    spp_pkg::spp_link_in_type sync1;
    spp_pkg::spp_link_in_type sync2;
    spp_pkg::spp_link_in_type prev;
    spp_state_type state;
    spp_state_type next_state;
    logic [WORD_W-1:0] rx_shift;
    logic [WORD_W-1:0] tx_shift;
    logic [spp_pkg::CNT_BITS-1:0] bit_cnt;
    logic [8:0] period_cnt;
    // Phase 1 first bit kept aside until the first leading edge
    logic tx_word_hold_msb;
    localparam logic [WORD_W-1:0] WORD_ZERO_W = '0;

    wire periph_mode = ~global_control_reg[spp_pkg::CTRL_SEL_BIT]; // R01
    wire phase = format_reg[spp_pkg::PHASE_BIT]; // R02
    wire polarity = format_reg[spp_pkg::POL_BIT]; // R03
    wire [7:0] prescale = format_reg[spp_pkg::PRESCALE_MSB:spp_pkg::PRESCALE_LSB];
    wire rise = sync2.sclk & ~prev.sclk;
    wire fall = ~sync2.sclk & prev.sclk;
    // Leading edge is rising for polarity 0, falling for polarity 1
    wire lead_edge = polarity ? fall : rise; // R03
    wire trail_edge = polarity ? rise : fall; // R03
    wire selected = periph_mode & ~sync2.cs_n;
    wire cs_fall = prev.cs_n & ~sync2.cs_n;
    wire cs_rise = ~prev.cs_n & sync2.cs_n;
    // Phase 0 samples on leading, phase 1 on trailing edge
    wire sample_edge = phase ? trail_edge : lead_edge; // R02
    wire launch_edge = phase ? lead_edge : trail_edge; // R02
    wire word_end = selected & sample_edge & (bit_cnt == spp_pkg::CNT_LAST); // R08
    // Least legal period: prescale+1 cycles, or 2 for zero, never below 25 ns
    wire [8:0] need_raw = (prescale == spp_pkg::PRESCALE_ZERO) ? spp_pkg::PER_PS0 :
        ({1'b0, prescale} + spp_pkg::PER_ONE);
    wire [8:0] need = (need_raw < 9'(spp_pkg::SCLK_MIN_CYC)) ?
        9'(spp_pkg::SCLK_MIN_CYC) : need_raw; // R04
    wire period_short = selected & rise & (period_cnt != spp_pkg::PER_NONE) &
        (period_cnt < need); // R04

    always_comb begin
        next_state = state;
        unique case (state)
            SPP_IDLE: begin
                if (selected) begin
                    next_state = SPP_SHIFT;
                end
            end
            SPP_SHIFT: begin
                if (!selected) begin
                    next_state = SPP_IDLE;
                end else if (word_end) begin
                    next_state = SPP_DONE;
                end
            end
            SPP_DONE: begin
                if (!selected) begin
                    next_state = SPP_IDLE;
                end
            end
            default: begin
                next_state = SPP_IDLE;
            end
        endcase
    end

    // Two-stage synchroniser on every link input
    always_ff @(posedge mclk) begin
        sync1 <= '{serial_clk_in, chip_sel_n, controller_out_line};
        sync2 <= sync1;
        prev <= sync2;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= SPP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Receive shifter, MSB first
    always_ff @(posedge mclk) begin
        if (srst || !selected) begin
            bit_cnt <= spp_pkg::CNT_ZERO;
            rx_shift <= WORD_ZERO_W;
        end else if (sample_edge && state == SPP_SHIFT) begin
            bit_cnt <= bit_cnt + spp_pkg::CNT_ONE; // R08
            rx_shift <= {rx_shift[WORD_W-2:0], sync2.mosi}; // R08
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_word <= WORD_ZERO_W;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= word_end;
            if (word_end) begin
                rx_word <= {rx_shift[WORD_W-2:0], sync2.mosi}; // R08
            end
        end
    end

    // Transmit shifter: word loaded at select, MSB out first.
    // Phase 0 must present the MSB before the first edge, so it is driven
    // at select; later bits launch on the launch edge.
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_shift <= WORD_ZERO_W;
            peripheral_out_line <= 1'b0;
            peripheral_out_oe <= 1'b0;
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            peripheral_out_oe <= selected;
            if (periph_mode && cs_fall) begin
                tx_shift <= {tx_word[WORD_W-2:0], 1'b0};
                peripheral_out_line <= phase ? 1'b0 : tx_word[WORD_W-1];
                tx_taken <= 1'b1;
            end else if (selected && launch_edge) begin
                if (phase && bit_cnt == spp_pkg::CNT_ZERO) begin
                    peripheral_out_line <= tx_word_hold_msb; // R05
                end else begin
                    peripheral_out_line <= tx_shift[WORD_W-1]; // R05
                    tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_word_hold_msb <= 1'b0;
        end else if (periph_mode && cs_fall) begin
            tx_word_hold_msb <= tx_word[WORD_W-1];
        end
    end

    // Period monitor between rising serial clock edges; it only flags,
    // since the host owns the clock and the block cannot slow it.
    always_ff @(posedge mclk) begin
        if (srst || !selected) begin
            period_cnt <= spp_pkg::PER_NONE;
        end else if (rise) begin
            period_cnt <= spp_pkg::PER_ONE;
        end else if (period_cnt != spp_pkg::PER_SAT && period_cnt != spp_pkg::PER_NONE) begin
            period_cnt <= period_cnt + spp_pkg::PER_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status <= '0;
        end else begin
            status.peripheral_mode <= periph_mode; // R01
            status.frame_active <= selected;
            // Sticky until reset; reset wins over a set in the same cycle
            status.period_error <= status.period_error | period_short; // R04
            // Word cut short by select rising: host broke framing
            status.framing_error <= status.framing_error |
                (cs_rise & periph_mode & (bit_cnt != spp_pkg::CNT_ZERO) &
                (state == SPP_SHIFT)); // R07
        end
    end

    chk_word_pulse: assert property (@(posedge mclk) disable iff (srst) // R08
        word_end |=> rx_valid ##1 !rx_valid)
        else $error("word pulse not one cycle");
    chk_mode_status: assert property (@(posedge mclk) disable iff (srst) // R01
        global_control_reg[spp_pkg::CTRL_SEL_BIT] |=> !status.peripheral_mode)
        else $error("mode status wrong");
    chk_oe_frame: assert property (@(posedge mclk) disable iff (srst) // R01
        (periph_mode && !sync2.cs_n) |=> peripheral_out_oe)
        else $error("output not enabled in frame");
    chk_oe_idle: assert property (@(posedge mclk) disable iff (srst) // R07
        sync2.cs_n |=> !peripheral_out_oe)
        else $error("output enabled outside frame");
    chk_period_flag: assert property (@(posedge mclk) disable iff (srst) // R04
        period_short |=> status.period_error)
        else $error("short period not flagged");
    chk_err_sticky: assert property (@(posedge mclk) disable iff (srst) // R04
        status.period_error |=> status.period_error)
        else $error("error flag dropped");
    chk_launch_edge: assert property (@(posedge mclk) disable iff (srst) // R05
        (selected && launch_edge && !phase && !cs_fall) |=>
        peripheral_out_line == $past(tx_shift[WORD_W-1]))
        else $error("bit not launched on edge");
    chk_count_bound: assert property (@(posedge mclk) disable iff (srst) // R08
        bit_cnt <= spp_pkg::CNT_FULL)
        else $error("bit count overflow");
    chk_capture_msb: assert property (@(posedge mclk) disable iff (srst) // R08
        word_end |=> rx_word[WORD_W-1] == $past(rx_shift[WORD_W-2]))
        else $error("word not MSB first");

    cov_word: cover property (@(posedge mclk) disable iff (srst) rx_valid);
    cov_phase1: cover property (@(posedge mclk) disable iff (srst) rx_valid && phase);
    cov_pol1: cover property (@(posedge mclk) disable iff (srst) rx_valid && polarity);
    cov_frame_err: cover property (@(posedge mclk) disable iff (srst)
        $rose(status.framing_error));

endmodule : spp_port

// ### pkg/spp_pkg.sv
// Package for the peripheral-mode serial port: configuration layout,
// word width and timing constants.
// Assumes one bus clock of 125 MHz feeding every register of the block.
package spp_pkg;

    // Bus clock period and serial clock minimum period
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned SCLK_MIN_PERIOD_NS = 25;
    // Least serial clock period in bus cycles, rounded up
    localparam int unsigned SCLK_MIN_CYC =
        (SCLK_MIN_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CNT_BITS = 5;

    // Field positions in the control words
    localparam int unsigned CTRL_SEL_BIT = 0;
    localparam int unsigned PHASE_BIT = 16;
    localparam int unsigned POL_BIT = 17;
    localparam int unsigned PRESCALE_LSB = 8;
    localparam int unsigned PRESCALE_MSB = 15;

    localparam logic [31:0] GCR_RESET = 32'h0000_0000;
    localparam logic [31:0] FMT_RESET = 32'h0000_0000;
    localparam logic [7:0] PRESCALE_ZERO = 8'h00;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_LAST = 5'h0f;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [4:0] CNT_FULL = 5'h10;

    // Period monitor counts, in bus cycles; saturates rather than wraps
    localparam logic [8:0] PER_NONE = 9'h000;
    localparam logic [8:0] PER_ONE = 9'h001;
    localparam logic [8:0] PER_PS0 = 9'h002;
    localparam logic [8:0] PER_SAT = 9'h1ff;

    // Pins of the serial link
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } spp_link_in_type;

    // Status flags
    typedef struct packed {
        logic peripheral_mode;
        logic frame_active;
        logic period_error;
        logic framing_error;
    } spp_status_type;

endpackage : spp_pkg

// ### verification/spp_host_model.sv
// Host-side model of the serial link: frames one word per chip select.
// Assumes the bench calls xfer from its own process, one call at a time.
module spp_host_model (
    // Clock
    input wire logic mclk,
    // Serial link pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 8;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic xfer(input logic pol, input logic pha, input logic [15:0] tx,
                        input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        sclk = pol;
        cs_n = 1'b0;
        // Two serial periods of quiet before the first edge
        repeat (4 * half) @(negedge mclk);
        for (int i = 0; i < nbits; i++) begin
            if (!pha) mosi = tx[15-i];
            repeat (half) @(negedge mclk);
            sclk = ~pol;
            if (pha) mosi = tx[15-i];
            else rx = {rx[14:0], miso};
            repeat (half) @(negedge mclk);
            sclk = pol;
            if (pha) rx = {rx[14:0], miso};
        end
        repeat (half) @(negedge mclk);
        cs_n = 1'b1;
        // Released line must not keep looking valid
        mosi = ~mosi;
        repeat (4 * half) @(negedge mclk);
    endtask : xfer
endmodule : spp_host_model

// ### verification/tb.sv
// Bench for the peripheral serial port: host model frames words, bench checks.
// Assumes the design answers within a few bus cycles of each serial edge.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] gcr = 32'h0000_0000;
    logic [31:0] fmt = 32'h0000_0000;
    logic [15:0] tx_word = 16'h0000;
    logic sclk, cs_n, mosi, miso, oe, rx_valid, tx_taken;
    logic [15:0] rx_word, got;
    spp_pkg::spp_status_type status;
    int failures = 0;
    int num_checks = 0;
    int n_rx = 0;
    int n_tx = 0;
    int n_act = 0;

    spp_port DUT (.mclk(mclk), .srst(srst), .global_control_reg(gcr), .format_reg(fmt),
        .serial_clk_in(sclk), .chip_sel_n(cs_n), .controller_out_line(mosi),
        .peripheral_out_line(miso), .peripheral_out_oe(oe), .tx_word(tx_word),
        .tx_taken(tx_taken), .rx_word(rx_word), .rx_valid(rx_valid), .status(status));
    spp_host_model host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    initial begin
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        n_rx += (rx_valid === 1'b1);
        n_tx += (tx_taken === 1'b1);
        n_act += (status.frame_active === 1'b1);
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic do_reset();
        @(negedge mclk);
        srst = 1'b1;
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        repeat (3) @(negedge mclk);
    endtask : do_reset

    task automatic run(input logic pol, input logic pha, input logic [7:0] ps,
                       input logic [15:0] w_host, input logic [15:0] w_dev, input int nbits);
        @(negedge mclk);
        fmt = {14'h0000, pol, pha, ps, 8'h00};
        tx_word = w_dev;
        n_rx = 0;
        n_tx = 0;
        n_act = 0;
        host.xfer(pol, pha, w_host, nbits, got);
        repeat (8) @(negedge mclk);
    endtask : run

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end

    initial begin
        do_reset();
        chk("mode", 16'h0001, {15'h0000, status.peripheral_mode});
        // Every phase and polarity, one word per select frame
        for (int m = 0; m < 4; m++) begin
            run(m[1], m[0], 8'h00, 16'ha5c3 ^ 16'(m), 16'h3c96 + 16'(m), 16);
            chk("rx_word", 16'ha5c3 ^ 16'(m), rx_word);
            chk("host_rx", 16'h3c96 + 16'(m), got);
            chk("rx_pulses", 16'h0001, 16'(n_rx));
            chk("tx_pulses", 16'h0001, 16'(n_tx));
            chk("oe_idle", 16'h0000, {15'h0000, oe});
            // Select low for 4 + 32 + 1 half periods of 8 bus cycles
            chk("frame_cycles", 16'h0128, 16'(n_act));
        end
        $display("test modes done");
        // Prescale 9: period of 10 cycles is legal, 8 is not
        host.half = 5;
        run(1'b0, 1'b0, 8'h09, 16'h8001, 16'h7ffe, 16);
        chk("period_ok", 16'h0000, {15'h0000, status.period_error});
        chk("rx_word", 16'h8001, rx_word);
        host.half = 4;
        run(1'b0, 1'b0, 8'h09, 16'h1234, 16'h4321, 16);
        chk("period_err", 16'h0001, {15'h0000, status.period_error});
        $display("test prescale done");
        host.half = 8;
        do_reset();
        run(1'b1, 1'b0, 8'h00, 16'hffff, 16'h0000, 8);
        chk("framing", 16'h0001, {15'h0000, status.framing_error});
        chk("rx_pulses", 16'h0000, 16'(n_rx));
        $display("test framing done");
        do_reset();
        gcr = 32'h0000_0001;
        run(1'b0, 1'b1, 8'h00, 16'h5a5a, 16'hc3c3, 16);
        chk("mode", 16'h0000, {15'h0000, status.peripheral_mode});
        chk("rx_pulses", 16'h0000, 16'(n_rx));
        chk("tx_pulses", 16'h0000, 16'(n_tx));
        chk("oe", 16'h0000, {15'h0000, oe});
        chk("frame_cycles", 16'h0000, 16'(n_act));
        $display("test controller mode done");
        tally_and_finish();
    end
endmodule : tb
